/* File: rtl/cfr_pkg.sv */
// Constants and carrier types for the channel function and ADC setup bank.
// Assumes a 16-bit word register port driven by the serial front end.
package cfr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_NO_OPERATION = 7'h00;
  localparam logic [6:0] ADDR_CHANNEL_FUNCTION_SELECT = 7'h01;
  localparam logic [6:0] ADDR_ADC_CONFIGURATION = 7'h02;
  localparam logic [15:0] RST_NO_OPERATION = 16'h0000;
  localparam logic [15:0] RST_CHANNEL_FUNCTION_SELECT = 16'h0000;
  localparam logic [15:0] RST_ADC_CONFIGURATION = 16'h2400;
  localparam logic [15:0] NOP_COMMAND = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int FUNC_LSB = 0;
  localparam int SECOND_CONVERSION_RATE_LSB = 13;
  localparam int FIRST_CONVERSION_RATE_LSB = 10;
  localparam int SECOND_CONVERSION_RANGE_LSB = 7;
  localparam int FIRST_CONVERSION_RANGE_LSB = 4;
  localparam int CONV2_SEL_LSB = 2;
  localparam int CONV1_SEL_LSB = 0;
  localparam logic [15:0] FUNC_MASK = 16'h000F;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CFR_FN_HIGH_Z = 4'h0,
    CFR_FN_VOLT_OUT = 4'h1,
    CFR_FN_CURR_OUT = 4'h2,
    CFR_FN_VOLT_IN = 4'h3,
    CFR_FN_CURR_IN_EXT = 4'h4,
    CFR_FN_CURR_IN_LOOP = 4'h5,
    CFR_FN_RES_2W = 4'h6,
    CFR_FN_RES_34W = 4'h7,
    CFR_FN_DIN_LOGIC = 4'h8,
    CFR_FN_DIN_LOOP = 4'h9
  } cfr_func_t;

  typedef enum logic [2:0] {
    CFR_RATE_10SPS = 3'h0,
    CFR_RATE_20SPS = 3'h1,
    CFR_RATE_1K2 = 3'h2,
    CFR_RATE_4K8 = 3'h3,
    CFR_RATE_9K6 = 3'h4
  } cfr_rate_t;

  typedef enum logic [2:0] {
    CFR_RNG_0_12V = 3'h0,
    CFR_RNG_PM12V = 3'h1,
    CFR_RNG_PM2V5 = 3'h2,
    CFR_RNG_NEG2V5 = 3'h3,
    CFR_RNG_0_2V5 = 3'h4,
    CFR_RNG_0_625MV = 3'h5,
    CFR_RNG_PM104MV = 3'h6
  } cfr_range_t;

  // Values loaded into conversion 1 when high-Z or an unlisted code is programmed
  localparam logic [2:0] HZ_FIRST_CONVERSION_RANGE = 3'h0;
  localparam logic [1:0] HZ_CONV1_SEL = 2'h0;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } cfr_req_t;

  typedef struct packed {
    cfr_rate_t second_conversion_rate;
    cfr_rate_t first_conversion_rate;
    cfr_range_t second_conversion_range;
    cfr_range_t first_conversion_range;
    logic [1:0] second_conversion_input_select;
    logic [1:0] first_conversion_input_select;
  } cfr_adc_cfg_t;

  // Pulse toward the other config banks when the function is written
  typedef struct packed {
    logic update;
    cfr_func_t function_code;
  } cfr_side_t;

endpackage

/* File: rtl/cfr_regs.sv */
// Channel function select and ADC configuration register bank.
// Assumes the serial front end presents one decoded word access per cycle.
//
// What this block does
// RULE_01: Write zero to address zero does nothing
// RULE_02: Function code bits 3:0, resets high-Z
// RULE_03: Codes 1-3 voltage/current out, voltage in
// RULE_04: Codes 4,5 current input ext/loop powered
// RULE_05: Codes 6,7 two-wire and multiwire resistance
// RULE_06: Codes 8,9 logic and loop digital input
// RULE_07: Unlisted function codes act as high-Z
// RULE_08: ADC stays usable in high-Z
// RULE_09: Host writes high-Z before new function
// RULE_10: Function write updates other config registers
// RULE_11: Function write rewrites conversion-1 range, input
// RULE_12: Host stops conversions before ADC config change
// RULE_13: Rates at bits 15:13 and 12:10
// RULE_14: Rate codes 0-4 map 10,20,1.2k,4.8k,9.6k
// RULE_15: Unlisted rate codes mean 20 SPS
// RULE_16: Ranges at bits 9:7 and 6:4
// RULE_17: Range codes 0-6 map listed spans
// RULE_18: Unlisted range codes mean 0-12 V
// RULE_19: Conversion-2 input select mapping bits 3:2
// RULE_20: Conversion-1 input select mapping bits 1:0
// RULE_21: Reserved bits read zero, writes ignored
`timescale 1ns/1ps

module cfr_regs (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire cfr_pkg::cfr_req_t req_i,
  input wire logic adc_busy_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output cfr_pkg::cfr_func_t active_function_o,
  output cfr_pkg::cfr_adc_cfg_t adc_cfg_o,
  output logic adc_enable_o,
  output cfr_pkg::cfr_side_t side_update_o,
  output logic sequence_error_o
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic wr_func;
  logic wr_adc;
  logic [3:0] func_q;
  logic [15:0] adc_q;
  logic [3:0] wr_code;

  assign wr_func = req_i.wr
    && (req_i.addr == cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT);
  assign wr_adc = req_i.wr
    && (req_i.addr == cfr_pkg::ADDR_ADC_CONFIGURATION);
  assign wr_code = req_i.wdata[cfr_pkg::FUNC_LSB +: 4];

  // ----------------------------------------------------------------------
  // Function select
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      func_q <= cfr_pkg::RST_CHANNEL_FUNCTION_SELECT[3:0]; // RULE_02
    end else if (wr_func) begin
      func_q <= wr_code; // RULE_21
    end
  end

  // Raw code is stored for readback; the decoded function falls back
  function automatic cfr_pkg::cfr_func_t decode_func(input logic [3:0] c);
    cfr_pkg::cfr_func_t f;
    f = cfr_pkg::CFR_FN_HIGH_Z;
    case (c)
      4'h1, 4'h2, 4'h3: f = cfr_pkg::cfr_func_t'(c); // RULE_03
      4'h4, 4'h5: f = cfr_pkg::cfr_func_t'(c); // RULE_04
      4'h6, 4'h7: f = cfr_pkg::cfr_func_t'(c); // RULE_05
      4'h8, 4'h9: f = cfr_pkg::cfr_func_t'(c); // RULE_06
      default: f = cfr_pkg::CFR_FN_HIGH_Z; // RULE_07
    endcase
    return f;
  endfunction

  function automatic cfr_pkg::cfr_rate_t decode_rate(input logic [2:0] c);
    cfr_pkg::cfr_rate_t r;
    r = cfr_pkg::CFR_RATE_20SPS;
    case (c)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: r = cfr_pkg::cfr_rate_t'(c); // RULE_14
      default: r = cfr_pkg::CFR_RATE_20SPS; // RULE_15
    endcase
    return r;
  endfunction

  function automatic cfr_pkg::cfr_range_t decode_range(input logic [2:0] c);
    cfr_pkg::cfr_range_t r;
    r = cfr_pkg::CFR_RNG_0_12V;
    case (c)
      3'h7: r = cfr_pkg::CFR_RNG_0_12V; // RULE_18
      default: r = cfr_pkg::cfr_range_t'(c); // RULE_17
    endcase
    return r;
  endfunction

  // Conversion-1 input and range implied by each function
  function automatic logic [4:0] func_conv1(input cfr_pkg::cfr_func_t f);
    logic [4:0] v;
    v = {cfr_pkg::HZ_FIRST_CONVERSION_RANGE, cfr_pkg::HZ_CONV1_SEL};
    case (f)
      cfr_pkg::CFR_FN_VOLT_OUT: v = {3'h2, 2'h1};
      cfr_pkg::CFR_FN_CURR_OUT: v = {3'h0, 2'h0};
      cfr_pkg::CFR_FN_VOLT_IN: v = {3'h0, 2'h0};
      cfr_pkg::CFR_FN_CURR_IN_EXT: v = {3'h2, 2'h1};
      cfr_pkg::CFR_FN_CURR_IN_LOOP: v = {3'h2, 2'h1};
      cfr_pkg::CFR_FN_RES_2W: v = {3'h4, 2'h0};
      cfr_pkg::CFR_FN_RES_34W: v = {3'h4, 2'h3};
      cfr_pkg::CFR_FN_DIN_LOGIC: v = {3'h0, 2'h0};
      cfr_pkg::CFR_FN_DIN_LOOP: v = {3'h0, 2'h0};
      default: v = {cfr_pkg::HZ_FIRST_CONVERSION_RANGE, cfr_pkg::HZ_CONV1_SEL};
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // ADC configuration
  // ----------------------------------------------------------------------
  logic [4:0] conv1_new;
  assign conv1_new = func_conv1(decode_func(wr_code));

  // A function write wins over a same-cycle ADC write for conversion 1
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      adc_q <= cfr_pkg::RST_ADC_CONFIGURATION;
    end else begin
      if (wr_adc) begin
        adc_q <= req_i.wdata; // RULE_13
      end
      if (wr_func) begin
        adc_q[cfr_pkg::FIRST_CONVERSION_RANGE_LSB +: 3] <= conv1_new[4:2]; // RULE_11
        adc_q[cfr_pkg::CONV1_SEL_LSB +: 2] <= conv1_new[1:0]; // RULE_11
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active_function_o <= cfr_pkg::CFR_FN_HIGH_Z;
      adc_cfg_o <= '0;
      adc_enable_o <= 1'b0;
    end else begin
      active_function_o <= decode_func(func_q);
      adc_cfg_o.second_conversion_rate <=
        decode_rate(adc_q[cfr_pkg::SECOND_CONVERSION_RATE_LSB +: 3]); // RULE_13
      adc_cfg_o.first_conversion_rate <=
        decode_rate(adc_q[cfr_pkg::FIRST_CONVERSION_RATE_LSB +: 3]); // RULE_13
      adc_cfg_o.second_conversion_range <=
        decode_range(adc_q[cfr_pkg::SECOND_CONVERSION_RANGE_LSB +: 3]); // RULE_16
      adc_cfg_o.first_conversion_range <=
        decode_range(adc_q[cfr_pkg::FIRST_CONVERSION_RANGE_LSB +: 3]); // RULE_16
      adc_cfg_o.second_conversion_input_select <=
        adc_q[cfr_pkg::CONV2_SEL_LSB +: 2]; // RULE_19
      adc_cfg_o.first_conversion_input_select <=
        adc_q[cfr_pkg::CONV1_SEL_LSB +: 2]; // RULE_20
      // The converter is never gated by the function, high-Z included
      adc_enable_o <= 1'b1; // RULE_08
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      side_update_o <= '0;
    end else begin
      side_update_o.update <= wr_func; // RULE_10
      side_update_o.function_code <= decode_func(wr_code);
    end
  end

  // Flags host sequencing slips; sticky until reset, never blocks a write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sequence_error_o <= 1'b0;
    end else if (wr_func && decode_func(wr_code) != cfr_pkg::CFR_FN_HIGH_Z
                 && decode_func(func_q) != cfr_pkg::CFR_FN_HIGH_Z) begin
      sequence_error_o <= 1'b1; // RULE_09
    end else if (wr_adc && adc_busy_i) begin
      sequence_error_o <= 1'b1; // RULE_12
    end
  end

  // ----------------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      case (req_i.addr)
        cfr_pkg::ADDR_NO_OPERATION: rdata_o <= cfr_pkg::RST_NO_OPERATION;
        cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT:
          rdata_o <= {12'h000, func_q}; // RULE_21
        cfr_pkg::ADDR_ADC_CONFIGURATION: rdata_o <= adc_q;
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_nop_write;
    req_i.wr && req_i.addr == cfr_pkg::ADDR_NO_OPERATION;
  endsequence

  a_nop_no_change: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_nop_write |=> $stable(func_q) && $stable(adc_q)) // RULE_01
    else $error("nop write changed state");

  a_func_reset_hz: assert property (@(posedge core_clk_i)
    !rst_n_i |=> func_q == 4'h0) // RULE_02
    else $error("function not high-Z after reset");

  a_func_stored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_func |=> func_q == $past(wr_code)) // RULE_03
    else $error("function code not stored");

  a_func_fallback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    func_q > 4'h9 |=> active_function_o == cfr_pkg::CFR_FN_HIGH_Z) // RULE_07
    else $error("reserved function not high-Z");

  a_conv1_rewrite: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_func |=> adc_q[6:4] == $past(conv1_new[4:2])
      && adc_q[1:0] == $past(conv1_new[1:0])) // RULE_11
    else $error("conversion-1 fields not rewritten");

  a_side_pulse: assert property ( // RULE_10
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_func |=> side_update_o.update
      ##1 (!side_update_o.update || $past(wr_func)))
    else $error("side update pulse wrong");

  a_rate_fallback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    adc_q[12:10] > 3'h4 |=> adc_cfg_o.first_conversion_rate
      == cfr_pkg::CFR_RATE_20SPS) // RULE_15
    else $error("reserved rate not 20 SPS");

  a_range_fallback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    adc_q[9:7] == 3'h7 |=> adc_cfg_o.second_conversion_range
      == cfr_pkg::CFR_RNG_0_12V) // RULE_18
    else $error("reserved range not 0-12 V");

  a_adc_in_hz: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    active_function_o == cfr_pkg::CFR_FN_HIGH_Z |-> ##1 adc_enable_o) // RULE_08
    else $error("adc disabled in high-Z");

  a_func_reserved0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rvalid_o && $past(req_i.addr) == cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT
      |-> rdata_o[15:4] == 12'h000) // RULE_21
    else $error("reserved bits not zero");

endmodule // cfr_regs

/* File: verif/cfr_regs_tb.sv */
// Self-checking bench for the channel function and ADC setup bank.
// Assumes cfr_pkg and cfr_regs are compiled first; one clock, sync reset.
`timescale 1ns/1ps

module cfr_regs_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cfr_pkg::cfr_req_t req_i = '0;
  logic adc_busy_i = 1'b0;
  logic [15:0] rdata_o;
  logic rvalid_o;
  cfr_pkg::cfr_func_t active_function_o;
  cfr_pkg::cfr_adc_cfg_t adc_cfg_o;
  logic adc_enable_o;
  cfr_pkg::cfr_side_t side_update_o;
  logic sequence_error_o;
  int fail_count = 0;
  int check_count = 0;
  integer seed = 51;
  logic [15:0] exp_q[$];
  logic [15:0] adc_model;
  logic [15:0] rnd;

  always #10 core_clk_i = ~core_clk_i;

  cfr_regs u_cfr_regs (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .adc_busy_i(adc_busy_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .active_function_o(active_function_o),
    .adc_cfg_o(adc_cfg_o),
    .adc_enable_o(adc_enable_o),
    .side_update_o(side_update_o),
    .sequence_error_o(sequence_error_o)
  );

  // ----------------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------------
  function automatic logic [15:0] exp_cfg(input logic [15:0] v);
    logic [2:0] r2;
    logic [2:0] r1;
    logic [2:0] g2;
    logic [2:0] g1;
    r2 = (v[15:13] > 3'h4) ? 3'h1 : v[15:13];
    r1 = (v[12:10] > 3'h4) ? 3'h1 : v[12:10];
    g2 = (v[9:7] > 3'h6) ? 3'h0 : v[9:7];
    g1 = (v[6:4] > 3'h6) ? 3'h0 : v[6:4];
    return {r2, r1, g2, g1, v[3:2], v[1:0]};
  endfunction

  // Conversion-1 range and input select loaded by a function write
  function automatic logic [4:0] conv1_dflt(input logic [3:0] f);
    case (f)
      4'h1, 4'h4, 4'h5: return 5'h09;
      4'h6: return 5'h10;
      4'h7: return 5'h13;
      default: return 5'h00;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read results are matched against the oldest note in arrival order
  always @(posedge core_clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD %0t unexpected read response", $time);
      end else begin
        chk(rdata_o, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req_i.wr <= 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_i);
    req_i.rd <= 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic set_func(input logic [3:0] f, input logic [11:0] junk);
    logic [3:0] dec;
    logic [4:0] c1;
    dec = (f > 4'h9) ? 4'h0 : f;
    c1 = conv1_dflt(f);
    wr(cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT, {junk, f});
    chk({15'h0, side_update_o.update}, 16'h0001);
    chk({12'h0, side_update_o.function_code}, {12'h0, dec});
    adc_model = {adc_model[15:7], c1[4:2], adc_model[3:2], c1[1:0]};
    rd(cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT, {12'h0, f});
    chk({15'h0, side_update_o.update}, 16'h0000);
    rd(cfr_pkg::ADDR_ADC_CONFIGURATION, adc_model);
    chk({12'h0, active_function_o}, {12'h0, dec});
    chk(16'(adc_cfg_o), exp_cfg(adc_model));
  endtask

  task automatic adc_wr(input logic [15:0] v);
    adc_model = v;
    wr(cfr_pkg::ADDR_ADC_CONFIGURATION, v);
    rd(cfr_pkg::ADDR_ADC_CONFIGURATION, v);
    chk(16'(adc_cfg_o), exp_cfg(v));
  endtask

  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    #1_000_000;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    adc_model = cfr_pkg::RST_ADC_CONFIGURATION;
    repeat (3) @(negedge core_clk_i);
    chk({15'h0, adc_enable_o}, 16'h0001);
    chk({12'h0, active_function_o}, 16'h0000);
    chk(16'(adc_cfg_o), exp_cfg(16'h2400));
    rd(cfr_pkg::ADDR_NO_OPERATION, 16'h0000);
    rd(cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT, 16'h0000);
    rd(cfr_pkg::ADDR_ADC_CONFIGURATION, 16'h2400);
    rd(7'h05, 16'h0000);
    // Writes to the read-only word must leave every register alone
    rnd = 16'($random(seed));
    wr(cfr_pkg::ADDR_NO_OPERATION, cfr_pkg::NOP_COMMAND);
    chk({15'h0, side_update_o.update}, 16'h0000);
    wr(cfr_pkg::ADDR_NO_OPERATION, rnd);
    rd(cfr_pkg::ADDR_NO_OPERATION, 16'h0000);
    rd(cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT, 16'h0000);
    rd(cfr_pkg::ADDR_ADC_CONFIGURATION, 16'h2400);
    for (int i = 0; i < 8; i++) begin
      rnd = 16'(i);
      adc_wr({rnd[2:0], rnd[2:0], rnd[2:0], rnd[2:0], rnd[1:0], rnd[1:0]});
    end
    for (int i = 0; i < 16; i++) begin
      rnd = 16'($random(seed));
      set_func(4'h0, rnd[15:4]);
      adc_wr(16'($random(seed)));
      set_func(4'(i), rnd[11:0]);
    end
    chk({15'h0, sequence_error_o}, 16'h0000);
    set_func(4'h1, 12'h000);
    set_func(4'h2, 12'h000);
    chk({15'h0, sequence_error_o}, 16'h0001);
    // Mid-run reset clears the sticky flag; then a busy ADC write sets it
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    adc_model = cfr_pkg::RST_ADC_CONFIGURATION;
    @(negedge core_clk_i);
    chk({15'h0, sequence_error_o}, 16'h0000);
    rd(cfr_pkg::ADDR_CHANNEL_FUNCTION_SELECT, 16'h0000);
    @(posedge core_clk_i);
    adc_busy_i <= 1'b1;
    adc_wr(16'($random(seed)));
    @(posedge core_clk_i);
    adc_busy_i <= 1'b0;
    @(negedge core_clk_i);
    chk({15'h0, sequence_error_o}, 16'h0001);
    repeat (4) @(negedge core_clk_i);
    chk(16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule // cfr_regs_tb
